// >>> src/shc_consts.vh
`ifndef SHC_CONSTS_VH
`define SHC_CONSTS_VH
// ************************************************************
// register offsets
// ************************************************************
`define SHC_ADDR_W        4
`define SHC_REG_CTRL      4'h0
`define SHC_REG_KEYCFG    4'h1
`define SHC_REG_CMD       4'h2
`define SHC_REG_STATE     4'h3
`define SHC_REG_IRQ_STAT  4'h4
`define SHC_REG_IRQ_MASK  4'h5
`define SHC_REG_STAB      4'h6
// ************************************************************
// control register fields
// ************************************************************
`define SHC_CTRL_MUTE_EN  0
`define SHC_CTRL_MUTE_POL 1
`define SHC_CTRL_STOP_LOW 2
`define SHC_CTRL_REL_CHG  3
`define SHC_CTRL_WAIT_CPU 4
`define SHC_CTRL_CPU_SUB  5
`define SHC_CTRL_PER_SUB  6
`define SHC_CTRL_MUTE_SET 7
`define SHC_CTRL_RESET    8'h00
// ************************************************************
// command register fields
// ************************************************************
`define SHC_CMD_HALT      0
`define SHC_CMD_WAIT      1
`define SHC_CMD_MUTE_CLR  2
// ************************************************************
// interrupt bits
// ************************************************************
`define SHC_IRQ_WAKE      0
`define SHC_IRQ_MUTE      1
`define SHC_IRQ_HOLD      2
`define SHC_IRQ_W         3
// ************************************************************
// timing and reset values
// ************************************************************
`define SHC_STAB_CYCLES   16'h1000
`define SHC_RESET_VECTOR  14'h0000
`endif

// >>> src/shc_stab.v
`timescale 1ns/1ps
// ************************************************************
// oscillator stabilisation counter
// ************************************************************
module shc_stab
(
    input  wire        clock,
    input  wire        rst,
    input  wire        start,
    input  wire [15:0] count,
    output wire        busy,
    output reg         done
)
;
    reg [15:0] remain;

    assign busy = (remain != 16'h0000);

    // counts down after restart; done pulses one cycle at zero
    always @(posedge clock)
    begin
        if (rst)
        begin
            remain <= 16'h0000;
            done   <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
                remain <= (count == 16'h0000) ? 16'h0001 : count;
            else if (busy)
            begin
                remain <= remain - 16'h0001;
                done   <= (remain == 16'h0001); // [RULE16]
            end
        end
    end
endmodule // shc_stab

// >>> src/shc_sync.v
`timescale 1ns/1ps
// ************************************************************
// two-stage synchroniser with change detect on settled bits
// ************************************************************
module shc_sync
#(
    parameter WIDTH = 5
)
(
    input  wire             clock,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] level,
    output reg  [WIDTH-1:0] changed
)
;
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] stage2;

    // first stage feeds only stage2; compare only settled values
    always @(posedge clock)
    begin
        if (rst)
        begin
            meta    <= {WIDTH{1'b0}};
            stage2  <= {WIDTH{1'b0}};
            level   <= {WIDTH{1'b0}};
            changed <= {WIDTH{1'b0}};
        end
        else
        begin
            meta    <= async_in;
            stage2  <= meta;
            level   <= stage2;
            changed <= stage2 ^ level; // [RULE17]
        end
    end
endmodule // shc_sync

// >>> src/shc_top.v
`timescale 1ns/1ps
`include "shc_consts.vh"
// Function
// [RULE1] mute output follows flag, set on input change
// [RULE2] software selects mute pin polarity
// [RULE3] clock-stop and wait, each own instruction
// [RULE4] clock-stop entry: immediate or on hold low
// [RULE5] clock-stop exit: hold high or input change
// [RULE6] clock-stop halts oscillator and cpu, retention
// [RULE7] wait entered regardless of hold level
// [RULE8] wait variant: oscillator only or cpu suspended
// [RULE9] wait released on any hold change
// [RULE10] key input bit change wakes from hold
// [RULE11] per-port pull-up or pull-down select
// [RULE12] cpu runs on main oscillator after reset
// [RULE13] software switches cpu and peripheral clocks
// [RULE14] either test input high means test mode
// [RULE15] execution starts at address zero after reset
// [RULE16] stabilisation count before resuming from stop
// [RULE17] inputs synchronised, change by compare
module shc_top
#(
    parameter STAB_CYCLES = `SHC_STAB_CYCLES
)
(
    input  wire                   clock,
    input  wire                   rst,
    input  wire [`SHC_ADDR_W-1:0] addr,
    input  wire [7:0]             wdata,
    input  wire                   wr,
    input  wire                   rd,
    output reg  [7:0]             rdata,
    input  wire                   clock_halt_instruction,
    input  wire                   wait_instruction,
    input  wire                   hold_in,
    input  wire [3:0]             key_port_bits,
    input  wire                   test_input,
    input  wire                   second_test_input,
    output reg                    mute_out,
    output wire                   main_osc_enable,
    output wire                   sub_osc_enable,
    output wire                   cpu_clock_enable,
    output wire                   cpu_clock_sub,
    output wire                   periph_clock_sub,
    output wire                   retention_mode,
    output wire [3:0]             key_pull_enable,
    output wire [3:0]             key_pull_up,
    output wire                   test_mode,
    output reg                    cpu_restart,
    output wire [13:0]            restart_address,
    output wire                   irq
)
;
    // ************************************************************
    // states
    // ************************************************************
    localparam ST_RUN   = 2'b00;
    localparam ST_ARMED = 2'b01;
    localparam ST_STOP  = 2'b10;
    localparam ST_WAIT  = 2'b11;

    // ************************************************************
    // registers and wires
    // ************************************************************
    reg  [7:0]  ctrl;
    reg  [7:0]  keycfg;
    reg  [15:0] stab_count;
    reg  [3:0]  irq_stat;
    reg  [3:0]  irq_mask;
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg         mute_flag;
    reg         boot_pend;
    wire [4:0]  sync_level;
    wire [4:0]  sync_chg;
    wire [1:0]  test_level;
    wire        hold_lvl;
    wire        hold_chg;
    wire        key_chg;
    wire        any_chg;
    wire        stab_busy;
    wire        stab_done;
    wire        stop_exit;
    wire        enter_stop;
    wire [3:0]  irq_event;
    wire [3:0]  irq_clear;
    wire        wait_osc_only;
    wire        park_main;
    wire        park_sub;

    // ************************************************************
    // decode helper
    // ************************************************************
    function hit;
        input [`SHC_ADDR_W-1:0] a;
        input [`SHC_ADDR_W-1:0] r;
        begin
            hit = (a == r);
        end
    endfunction

    // ************************************************************
    // input synchronisers
    // ************************************************************
    shc_sync
    #(
        .WIDTH    (5)
    )
    u_sync
    (
        .clock    (clock),
        .rst      (rst),
        .async_in ({hold_in, key_port_bits}),
        .level    (sync_level),
        .changed  (sync_chg)
    );

    // test pins come from outside too
    shc_sync
    #(
        .WIDTH    (2)
    )
    u_test_sync
    (
        .clock    (clock),
        .rst      (rst),
        .async_in ({second_test_input, test_input}),
        .level    (test_level),
        .changed  ()
    );

    // bit 4 is hold, bits 3:0 the key port
    assign hold_lvl = sync_level[4];
    assign hold_chg = sync_chg[4];
    // only bits configured as inputs can wake
    assign key_chg  = |(sync_chg[3:0] & keycfg[3:0]); // [RULE10]
    // hold and enabled keys share one wake source
    assign any_chg  = hold_chg | key_chg;

    // ************************************************************
    // oscillator restart delay
    // ************************************************************
    shc_stab u_stab
    (
        .clock (clock),
        .rst   (rst),
        .start (stop_exit),
        .count (stab_count),
        .busy  (stab_busy),
        .done  (stab_done)
    );

    // ************************************************************
    // hold state machine
    // ************************************************************
    // low-detect entry either now or once hold reads low
    assign enter_stop = ctrl[`SHC_CTRL_STOP_LOW] ? ~hold_lvl : 1'b1; // [RULE4]
    // release condition chosen in control register
    assign stop_exit  = (state == ST_STOP) &&
                        (ctrl[`SHC_CTRL_REL_CHG] ? any_chg
                                                 : hold_lvl); // [RULE5]

    always @*
    begin
        next_state = state;
        case (state)
            ST_RUN:
            begin
                if (stab_busy)
                    next_state = ST_RUN;
                else if (clock_halt_instruction) // [RULE3]
                    next_state = enter_stop ? ST_STOP : ST_ARMED;
                else if (wait_instruction)
                    next_state = ST_WAIT; // [RULE7]
            end
            ST_ARMED:
                if (~hold_lvl)
                    next_state = ST_STOP;
            ST_STOP:
                if (stop_exit)
                    next_state = ST_RUN;
            ST_WAIT:
                // hold change or enabled key change wakes
                if (hold_chg | key_chg) // [RULE9]
                    next_state = ST_RUN;
            default:
                next_state = ST_RUN;
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    always @(posedge clock)
    begin
        if (rst)
            state <= ST_RUN;
        else
            state <= next_state;
    end

    // ************************************************************
    // oscillator enables
    // ************************************************************
    // osc-only wait parks the crystal that the cpu is not using
    assign wait_osc_only    = (state == ST_WAIT) &
                              ~ctrl[`SHC_CTRL_WAIT_CPU]; // [RULE8]
    assign park_main        = wait_osc_only & ctrl[`SHC_CTRL_CPU_SUB];
    assign park_sub         = wait_osc_only & ~ctrl[`SHC_CTRL_CPU_SUB];
    // stop kills both oscillators, cpu, keeps memory retained
    assign main_osc_enable  = (state != ST_STOP) & ~park_main; // [RULE6]
    assign sub_osc_enable   = (state != ST_STOP) & ~park_sub;
    assign retention_mode   = (state == ST_STOP);
    // ************************************************************
    // clock selects and static outputs
    // ************************************************************
    // wait variant: cpu only suspended keeps clocks, else osc only
    assign cpu_clock_enable = (state == ST_RUN) & ~stab_busy; // [RULE16]
    assign periph_clock_sub = ctrl[`SHC_CTRL_PER_SUB]; // [RULE13]
    assign cpu_clock_sub    = ctrl[`SHC_CTRL_CPU_SUB]; // [RULE12]
    assign test_mode        = |test_level; // [RULE14]
    assign restart_address  = `SHC_RESET_VECTOR; // [RULE15]
    // pull enable for input bits, direction chosen per bit
    assign key_pull_enable  = keycfg[3:0]; // [RULE11]
    assign key_pull_up      = keycfg[7:4];

    // ************************************************************
    // cpu restart pulse: after reset and after stabilisation
    // ************************************************************
    always @(posedge clock)
    begin
        if (rst)
        begin
            boot_pend   <= 1'b1;
            cpu_restart <= 1'b0;
        end
        else
        begin
            boot_pend   <= 1'b0;
            cpu_restart <= boot_pend | stab_done;
        end
    end

    // ************************************************************
    // mute flag and pin
    // ************************************************************
    // set wins over a software clear in the same cycle
    always @(posedge clock)
    begin
        if (rst)
        begin
            mute_flag <= 1'b0;
            mute_out  <= 1'b0;
        end
        else
        begin
            if (ctrl[`SHC_CTRL_MUTE_EN] & any_chg)
                mute_flag <= 1'b1; // [RULE1]
            else if (wr && hit(addr, `SHC_REG_CTRL) &&
                     wdata[`SHC_CTRL_MUTE_SET])
                mute_flag <= 1'b1;
            else if (wr && hit(addr, `SHC_REG_CMD) &&
                     wdata[`SHC_CMD_MUTE_CLR])
                mute_flag <= 1'b0;
            mute_out <= mute_flag ^ ctrl[`SHC_CTRL_MUTE_POL]; // [RULE2]
        end
    end

    // ************************************************************
    // register writes
    // ************************************************************
    // ctrl bit 7 is a strobe and is never stored
    always @(posedge clock)
    begin
        if (rst)
        begin
            ctrl       <= `SHC_CTRL_RESET;
            keycfg     <= 8'h00;
            irq_mask   <= 4'h0;
            stab_count <= STAB_CYCLES[15:0];
        end
        else if (wr)
        begin
            if (hit(addr, `SHC_REG_CTRL))
                ctrl <= {1'b0, wdata[6:0]};
            if (hit(addr, `SHC_REG_KEYCFG))
                keycfg <= wdata;
            if (hit(addr, `SHC_REG_IRQ_MASK))
                irq_mask <= wdata[3:0];
            // settle count loads in whole 256-cycle steps
            if (hit(addr, `SHC_REG_STAB))
                stab_count <= {wdata, 8'h00};
        end
    end

    // ************************************************************
    // interrupt status, write one to clear, set wins
    // ************************************************************
    // wake covers both the end of settling and leaving wait
    assign irq_event[`SHC_IRQ_WAKE] = stab_done |
                                      ((state == ST_WAIT) &&
                                       (next_state == ST_RUN));
    assign irq_event[`SHC_IRQ_MUTE] = ctrl[`SHC_CTRL_MUTE_EN] & any_chg;
    assign irq_event[`SHC_IRQ_HOLD] = hold_chg;
    assign irq_event[3]             = key_chg;
    // clear strobe only on a write to the status register
    assign irq_clear = (wr && hit(addr, `SHC_REG_IRQ_STAT)) ?
                       wdata[3:0] : 4'h0;

    always @(posedge clock)
    begin
        if (rst)
            irq_stat <= 4'h0;
        else
            irq_stat <= (irq_stat & ~irq_clear) | irq_event;
    end

    // level interrupt; mask gates the pin, not the status
    assign irq = |(irq_stat & irq_mask);

    // ************************************************************
    // register reads, one cycle later
    // ************************************************************
    // idle cycles return zero so read data can be or-ed
    always @(posedge clock)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (rd)
        begin
            case (addr)
                `SHC_REG_CTRL:     rdata <= {mute_flag, ctrl[6:0]};
                `SHC_REG_KEYCFG:   rdata <= keycfg;
                `SHC_REG_STATE:    rdata <= {test_mode, stab_busy,
                                             sync_level, state[0]};
                `SHC_REG_IRQ_STAT: rdata <= {4'h0, irq_stat};
                `SHC_REG_IRQ_MASK: rdata <= {4'h0, irq_mask};
                `SHC_REG_STAB:     rdata <= stab_count[15:8];
                default:           rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end
endmodule // shc_top

// >>> test/shc_asserts.sv
`timescale 1ns/1ps
// ***
// port checks
// ***
module shc_asserts
#(
    parameter STAB_CYCLES = 16'h1000
)
(
    input wire        clock,
    input wire        rst,
    input wire        wait_instruction,
    input wire        test_input,
    input wire        second_test_input,
    input wire        main_osc_enable,
    input wire        sub_osc_enable,
    input wire        cpu_clock_enable,
    input wire        retention_mode,
    input wire        test_mode,
    input wire        cpu_restart,
    input wire [13:0] restart_address
);
    reg [16:0] since;
    reg        stopped;
    // cycles since stop was left; saturates so it never wraps
    always @(posedge clock)
    begin
        if (rst || retention_mode)
            since <= 17'h00000;
        else if (since != 17'h1ffff)
            since <= since + 17'h00001;
        stopped <= !rst && (retention_mode || (stopped && !cpu_restart));
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ***
    // properties
    // ***
    property p_osc;
        retention_mode |-> !main_osc_enable && !sub_osc_enable;
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator on in stop");
    property p_cpu;
        retention_mode |-> !cpu_clock_enable && !cpu_restart;
    endproperty
    a_cpu: assert property (p_cpu)
        else $error("cpu running in stop");
    property p_addr;
        restart_address == 14'h0000;
    endproperty
    a_addr: assert property (p_addr)
        else $error("restart address not zero");
    property p_run;
        cpu_restart |=> cpu_clock_enable && !cpu_restart;
    endproperty
    a_run: assert property (p_run)
        else $error("restart pulse wrong");
    property p_wait;
        wait_instruction && cpu_clock_enable |=> !cpu_clock_enable;
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait not entered");
    property p_test_on;
        (test_input || second_test_input) [*4] |-> test_mode;
    endproperty
    a_test_on: assert property (p_test_on)
        else $error("test mode missing");
    property p_test_off;
        (!test_input && !second_test_input) [*4] |-> !test_mode;
    endproperty
    a_test_off: assert property (p_test_off)
        else $error("test mode stuck");
    property p_stab_min;
        cpu_restart && stopped |-> since >= STAB_CYCLES;
    endproperty
    a_stab_min: assert property (p_stab_min)
        else $error("restart before settle count");
    property p_stab_max;
        stopped && !retention_mode |-> since <= STAB_CYCLES + 8;
    endproperty
    a_stab_max: assert property (p_stab_max)
        else $error("restart too late");
    c_stop: cover property (retention_mode);
    c_wake: cover property (cpu_restart && stopped);
    c_wait: cover property (wait_instruction && cpu_clock_enable);
endmodule // shc_asserts
bind shc_top shc_asserts #(.STAB_CYCLES(STAB_CYCLES)) u_chk
(
    .clock(clock), .rst(rst), .wait_instruction(wait_instruction),
    .test_input(test_input), .second_test_input(second_test_input),
    .main_osc_enable(main_osc_enable), .sub_osc_enable(sub_osc_enable),
    .cpu_clock_enable(cpu_clock_enable), .retention_mode(retention_mode),
    .test_mode(test_mode), .cpu_restart(cpu_restart),
    .restart_address(restart_address)
);

// >>> test/shc_partner.sv
`timescale 1ns/1ps
// ***
// hold detector and key pad
// ***
module shc_partner
(
    input  wire       clock,
    input  wire       slow,
    input  wire       hold_req,
    input  wire [3:0] press,
    input  wire [3:0] pull_en,
    input  wire [3:0] pull_up,
    output reg        hold_in,
    output reg  [3:0] key_port_bits
);
    reg [4:0] lag;
    integer   i;
    initial
    begin
        hold_in = 1'b1;
        key_port_bits = 4'h0;
        lag = 5'h1f;
    end
    // detector answers at once or five cycles late
    always @(posedge clock)
    begin
        lag <= {lag[3:0], hold_req};
        hold_in <= slow ? lag[4] : hold_req;
    end
    // pressed key fights its pull; unpulled lines wander
    always @(posedge clock)
        for (i = 0; i < 4; i = i + 1)
            key_port_bits[i] <= pull_en[i] ? press[i] ^ pull_up[i]
                                           : ~key_port_bits[i];
endmodule // shc_partner

// >>> test/standby_hold_controller_bench.sv
`timescale 1ns/1ps
// ***
// bench
// ***
module standby_hold_controller_bench;
    localparam STAB = 16'h0008;
    reg         clock = 1'b0;
    reg         rst = 1'b1;
    reg  [3:0]  addr = 4'h0;
    reg  [7:0]  wdata = 8'h00;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    reg         halt = 1'b0;
    reg         waiti = 1'b0;
    reg  [1:0]  tin = 2'h0;
    reg         slow = 1'b0;
    reg         hold_req = 1'b1;
    reg  [3:0]  press = 4'h0;
    reg  [7:0]  d;
    wire [7:0]  rdata;
    wire [3:0]  keys, pull_en, pull_up;
    wire [13:0] raddr;
    wire        hold_in, mute, mosc, sosc, cpu_en, csub, psub, ret;
    wire        tmode, rstart, irq;
    wire [3:0]  mon = {mute, rstart, cpu_en, ret};
    integer     bad_count = 0;
    integer     n_checks = 0;
    integer     cycles = 0;
    integer     k, n;
    // short settle count keeps the run brief
    shc_top #(.STAB_CYCLES(STAB)) DUT
    (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .clock_halt_instruction(halt),
        .wait_instruction(waiti), .hold_in(hold_in), .key_port_bits(keys),
        .test_input(tin[0]), .second_test_input(tin[1]), .mute_out(mute),
        .main_osc_enable(mosc), .sub_osc_enable(sosc),
        .cpu_clock_enable(cpu_en), .cpu_clock_sub(csub),
        .periph_clock_sub(psub), .retention_mode(ret),
        .key_pull_enable(pull_en), .key_pull_up(pull_up), .test_mode(tmode),
        .cpu_restart(rstart), .restart_address(raddr), .irq(irq)
    );
    shc_partner FAR
    (
        .clock(clock), .slow(slow), .hold_req(hold_req), .press(press),
        .pull_en(pull_en), .pull_up(pull_up), .hold_in(hold_in),
        .key_port_bits(keys)
    );
    always #12.5 clock = ~clock;
    // hang guard
    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            bad_count = bad_count + 1;
            print_verdict;
        end
    end
    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    task check(input [15:0] seen, input [15:0] exp);
    begin
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: %h not %h", $time, seen, exp);
        end
    end
    endtask
    task tick(input integer c);
    begin
        repeat (c) @(posedge clock);
        #1;
    end
    endtask
    task wr_reg(input [3:0] a, input [7:0] v);
    begin
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    end
    endtask
    task rd_reg(input [3:0] a);
    begin
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    end
    endtask
    // instruction pulse: 1 = wait, 0 = clock halt
    task pulse(input w);
    begin
        @(posedge clock);
        waiti <= w;
        halt <= !w;
        @(posedge clock);
        waiti <= 1'b0;
        halt <= 1'b0;
    end
    endtask
    // bounded wait on one monitored output
    task wait_on(input [1:0] s, input v);
    begin
        n = 0;
        do
        begin
            @(posedge clock);
            #1;
            n = n + 1;
        end
        while (mon[s] !== v && n < 40);
    end
    endtask
    task flip_hold;
    begin
        @(posedge clock);
        hold_req <= ~hold_req;
        tick(16);
    end
    endtask
    // ***
    // scenarios
    // ***
    task t_reset;
    begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        wait_on(2'h2, 1'b1);
        check(rstart, 1'b1);
        check(raddr, 14'h0000);
        check({mosc, csub, psub}, 3'h4);
        rd_reg(4'h0);
        check(d, 8'h00);
        $display("reset test done");
    end
    endtask
    task t_config;
    begin
        wr_reg(4'h1, 8'ha5);
        tick(1);
        check({pull_up, pull_en}, 8'ha5);
        for (k = 0; k < 3; k = k + 1)
        begin
            wr_reg(4'h0, 8'h10 << k);
            tick(1);
            check({psub, csub}, k);
            rd_reg(4'h0);
            check(d, 8'h10 << k);
        end
        wr_reg(4'h0, 8'h00);
        for (k = 0; k < 4; k = k + 1)
        begin
            @(posedge clock);
            tin <= k;
            tick(5);
            check(tmode, k != 0);
        end
        @(posedge clock);
        tin <= 2'h0;
        $display("config test done");
    end
    endtask
    task t_mute;
    begin
        wr_reg(4'h0, 8'h01);
        flip_hold;
        check(mute, 1'b1);
        rd_reg(4'h4);
        check(d[1], 1'b1);
        wr_reg(4'h5, 8'h02);
        tick(1);
        check(irq, 1'b1);
        wr_reg(4'h4, 8'h02);
        tick(1);
        check(irq, 1'b0);
        wr_reg(4'h0, 8'h03);
        tick(2);
        check(mute, 1'b0);
        wr_reg(4'h2, 8'h04);
        tick(2);
        check(mute, 1'b1);
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h5, 8'h00);
        flip_hold;
        check(mute, 1'b0);
        $display("mute test done");
    end
    endtask
    // stop, then wake by hold high (key 0) or a key press
    task t_stop(input [7:0] ctl, input [3:0] key);
    begin
        wr_reg(4'h1, 8'h01);
        wr_reg(4'h0, ctl);
        @(posedge clock);
        slow <= 1'b1;
        hold_req <= 1'b0;
        tick(12);
        pulse(1'b0);
        wait_on(2'h0, 1'b1);
        check(n < 3, 1'b1);
        tick(10);
        check({ret, mosc, sosc, cpu_en}, 4'h8);
        @(posedge clock);
        hold_req <= (key == 4'h0);
        press <= key;
        wait_on(2'h0, 1'b0);
        check(ret, 1'b0);
        wait_on(2'h2, 1'b1);
        check(n >= STAB - 1 && n <= STAB + 3, 1'b1);
        @(posedge clock);
        press <= 4'h0;
        hold_req <= 1'b1;
        tick(16);
        $display("stop test done");
    end
    endtask
    task t_stop_low;
    begin
        wr_reg(4'h0, 8'h04);
        pulse(1'b0);
        tick(6);
        check(ret, 1'b0);
        @(posedge clock);
        hold_req <= 1'b0;
        wait_on(2'h0, 1'b1);
        check(ret, 1'b1);
        @(posedge clock);
        hold_req <= 1'b1;
        wait_on(2'h0, 1'b0);
        check(ret, 1'b0);
        wait_on(2'h2, 1'b1);
        check(rstart, 1'b1);
        $display("stop on hold low test done");
    end
    endtask
    task t_wait;
    begin
        for (k = 0; k < 2; k = k + 1)
        begin
            wr_reg(4'h0, {3'h0, k[0], 4'h4});
            @(posedge clock);
            slow <= k;
            hold_req <= k;
            tick(16);
            pulse(1'b1);
            wait_on(2'h1, 1'b0);
            check(n < 3, 1'b1);
            tick(8);
            check(cpu_en, 1'b0);
            check({mosc, sosc}, 2'h2 | k);
            flip_hold;
            check(cpu_en, 1'b1);
        end
        $display("wait test done");
    end
    endtask
    initial
    begin
        t_reset;
        t_config;
        t_mute;
        t_stop(8'h00, 4'h0);
        t_stop(8'h08, 4'h1);
        t_stop_low;
        t_wait;
        print_verdict;
    end
endmodule // standby_hold_controller_bench
